// file: dv/mbs_master.sv
// query master model: sends requests and collects answer bytes
`timescale 1ns/10ps
`default_nettype none
module mbs_master (
  input  wire logic        clk,
  input  wire logic        rxReady,
  output logic             rxValid,
  output logic      [7:0]  rxData,
  output logic             rxLast,
  output logic      [31:0] rxMaster,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  input  wire logic        txLast,
  input  wire logic        stall,
  output logic             txReady
);
  logic [7:0] ans[$];
  int         lastAt;
  initial {rxValid, rxData, rxLast, rxMaster, txReady} = '0;
  task automatic send(input logic [7:0] b[$], input logic [31:0] m);
    foreach (b[i])
    begin
      rxValid  <= 1'b1;
      rxData   <= b[i];
      rxLast   <= (i == b.size() - 1);
      rxMaster <= m;
      do @(posedge clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxLast  <= 1'b0;
    // released line must not keep showing the last byte
    rxData  <= ~rxData;
  endtask
  always @(posedge clk)
  begin
    if (txValid && txReady)
    begin
      ans.push_back(txData);
      if (txLast)
        lastAt = ans.size();
    end
    txReady <= !stall;
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the request interpreter
`timescale 1ns/10ps
`default_nettype none
`include "mbs_cfg.svh"
module tb_top;
  logic clk = 0, rst_n = 0, wdExpired = 0, termBusErr = 0, stall = 0, slow = 0;
  logic rxValid, rxLast, rxReady, txValid, txLast, txReady, fwdReq, answerDone, errAnswer, inWrEn = 0;
  logic [7:0]  rxData, txData, fwdFunc, inWrAddr = 0, outRdAddr = 0;
  logic [31:0] rxMaster;
  logic [15:0] wdTime, outRdData, inWrData = 0;
  int seed = 15, badCount = 0, comparisons = 0, held = 0, owner = 0, w;
  int outImg[256], inImg[256], wdt = `MBS_WDTIME_RST;
  int fwdCodes[4] = '{8, 15, 16, 23};
  int badCodes[8] = '{0, 7, 9, 14, 17, 22, 24, 255};
  always #5 clk = ~clk;
  always @(posedge clk) stall <= slow & $random(seed);
  mbs_slave #(.OWNER_HOLD_CYC(50)) dut_u (.clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxMaster(rxMaster), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady), .wdExpired(wdExpired), .termBusErr(termBusErr), .fwdReq(fwdReq),
    .fwdFunc(fwdFunc), .answerDone(answerDone), .errAnswer(errAnswer), .wdTime(wdTime), .inWrEn(inWrEn),
    .inWrAddr(inWrAddr), .inWrData(inWrData), .outRdAddr(outRdAddr), .outRdData(outRdData));
  mbs_master mst_u (.clk(clk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxMaster(rxMaster), .txValid(txValid), .txData(txData), .txLast(txLast), .stall(stall),
    .txReady(txReady));
  // ----------------------------------------
  // reference model and checks
  // ----------------------------------------
  function automatic void model(input int f, a, q, m, output logic [7:0] p[$]);
    int e, n, b;
    e = 0;
    if (!(f inside {[1:6]})) e = 1;
    else if (wdExpired | termBusErr) e = 4;
    else if (f < 3 && (q < 1 || q > 2000 || a + q > 4096)) e = 2;
    else if (f inside {3, 4} && !(q inside {[1:125]} && (a + q <= 256 || f == 3 && a >= 2048
      && a + q <= 2304 || q == 1 && a inside {4108, 4384}))) e = 2;
    else if (f == 5 && a >= 4096) e = 2;
    else if (f == 5 && !(q inside {16'hff00, 16'h0000})) e = 3;
    else if (f == 6 && !(a inside {[2048:2303], [4096:8191]})) e = 2;
    else if (f == 6 && a >= 4096 && a != 4384) e = 3;
    else if (f > 4 && held && m != owner) e = 6;
    p = {8'(f)};
    if (e)
      p = {8'(f) | 8'h80, 8'(e)};
    else if (f < 3)
    begin
      p.push_back(8'((q + 7) / 8));
      for (int j = 0; j < (q + 7) / 8; j++)
      begin
        n = 0;
        for (int k = 0; k < 8; k++)
        begin
          b = a + 8 * j + k;
          if (8 * j + k < q)
            n |= (((f == 1) ? outImg[b >> 4] : inImg[b >> 4]) >> (b & 15) & 1) << k;
        end
        p.push_back(8'(n));
      end
    end
    else if (f < 5)
    begin
      p.push_back(8'(2 * q));
      for (int i = a; i < a + q; i++)
      begin
        n = (i == 4108) ? {wdExpired, 14'h0, termBusErr} : (i == 4384) ? wdt
          : (i >= 2048) ? outImg[i - 2048] : inImg[i];
        p.push_back(8'(n >> 8));
        p.push_back(8'(n));
      end
    end
    else
    begin
      p = {8'(f), 8'(a >> 8), 8'(a), 8'(q >> 8), 8'(q)};
      held = 1;
      owner = m;
      if (f == 5) outImg[a >> 4][a & 15] = (q != 0);
      else if (a == 4384) wdt = q;
      else outImg[a - 2048] = q & 16'hffff;
    end
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkAns(input logic [7:0] e[$]);
    chk("answer length", e.size(), mst_u.ans.size());
    foreach (e[i]) chk("answer byte", e[i], mst_u.ans[i]);
    if (e.size()) chk("last byte", e.size(), mst_u.lastAt);
  endtask
  task automatic run(input int f, a, q, m);
    logic [7:0]  r[$], p[$];
    logic [15:0] t;
    logic [7:0]  u;
    int k;
    // one edge so that level inputs set just before are seen by model and design alike
    @(posedge clk);
    t = $random(seed);
    u = $random(seed);
    if (!(f inside {8, 15, 16, 23})) model(f, a, q, m, p);
    r = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h06, u, 8'(f), 8'(a >> 8), 8'(a), 8'(q >> 8), 8'(q)};
    mst_u.ans.delete();
    mst_u.lastAt = 0;
    mst_u.send(r, m);
    k = 0;
    do begin @(posedge clk); k++; end while (k < 3000 && answerDone !== 1'b1 && fwdReq !== 1'b1);
    chk("answer wait", 1, k < 3000);
    if (f inside {8, 15, 16, 23})
    begin
      repeat (20) @(posedge clk);
      chk("forwarded code", f, fwdFunc);
      r = {};
    end
    else
    begin
      chk("error flag", p[0][7], errAnswer);
      r = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'(p.size() + 1), u, p};
    end
    chkAns(r);
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (60000) @(posedge clk);
    badCount++;
    testDone();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("wdTime reset", `MBS_WDTIME_RST, wdTime);
    for (int i = 0; i < 256; i++)
    begin
      w = $random(seed) & 16'hffff;
      inImg[i] = w;
      inWrEn <= 1'b1;
      inWrAddr <= 8'(i);
      inWrData <= 16'(w);
      @(posedge clk);
    end
    inWrEn <= 1'b0;
    for (int i = 0; i < 256; i++) run(6, 2048 + i, $random(seed) & 16'hffff, 1);
    for (int i = 0; i < 256; i++)
    begin
      outRdAddr <= 8'(i);
      repeat (2) @(posedge clk);
      chk("output word", outImg[i], outRdData);
    end
    slow <= 1'b1;
    run(3, 0, 125, 1);
    run(3, 2248, 56, 1);
    run(3, 2249, 56, 1);
    run(3, 0, 0, 1);
    run(3, 0, 126, 1);
    run(4, 250, 6, 1);
    run(4, 2048, 1, 1);
    run(1, 3, 10, 1);
    run(1, 4095, 1, 1);
    run(1, 4090, 7, 1);
    run(1, 0, 0, 1);
    run(2, 5, 2000, 1);
    run(2, 0, 2001, 1);
    run(5, 2, 16'hff00, 1);
    run(5, 19, 16'hff00, 1);
    run(5, 3, 16'h0000, 1);
    run(5, 7, 16'hff01, 1);
    run(5, 4096, 0, 1);
    run(1, 0, 21, 1);
    run(6, 16'h1120, 16'h0100, 1);
    chk("wdTime", 16'h0100, wdTime);
    run(3, 16'h1120, 1, 1);
    run(4, 16'h100c, 1, 1);
    run(3, 16'h100c, 2, 1);
    run(6, 16'h100c, 5, 1);
    foreach (fwdCodes[i]) run(fwdCodes[i], 0, 1, 1);
    slow <= 1'b0;
    run(6, 2048, 9, 1);
    run(6, 2048, 5, 2);
    repeat (60) @(posedge clk);
    held = 0;
    run(5, 0, 0, 2);
    run(6, 2049, 3, 1);
    wdExpired <= 1'b1;
    foreach (badCodes[i]) run(badCodes[i], 0, 1, 1);
    run(3, 0, 1, 1);
    wdExpired <= 1'b0;
    termBusErr <= 1'b1;
    run(1, 0, 1, 1);
    termBusErr <= 1'b0;
    run(3, 16'h100c, 1, 1);
    testDone();
  end
endmodule
`default_nettype wire

// file: inc/mbs_cfg.svh
// offsets, codes, field positions and timing of the request interpreter
`ifndef MBS_CFG_SVH
`define MBS_CFG_SVH
`define MBS_CLK_HZ        100000000
`define MBS_OWNER_HOLD_MS 1000
`define MBS_REQ_LEN       4'hc
`define MBS_HDR_LEN       4'h8
`define MBS_IDX_TID       4'h0
`define MBS_IDX_PROTO     4'h2
`define MBS_IDX_UNIT      4'h6
`define MBS_IDX_FUNC      4'h7
`define MBS_IDX_ADDR      4'h8
`define MBS_IDX_QTY       4'ha
`define MBS_PDU_POS       8'h07
`define MBS_FN_RD_COILS   8'h01
`define MBS_FN_RD_INPUTS  8'h02
`define MBS_FN_RD_HOLD    8'h03
`define MBS_FN_RD_INREG   8'h04
`define MBS_FN_WR_COIL    8'h05
`define MBS_FN_WR_REG     8'h06
`define MBS_FN_DIAG       8'h08
`define MBS_FN_WR_COILS   8'h0f
`define MBS_FN_WR_REGS    8'h10
`define MBS_FN_RW_REGS    8'h17
`define MBS_EXC_FLAG      8'h80
`define MBS_EXC_FUNC      8'h01
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_VALUE     8'h03
`define MBS_EXC_DEVICE    8'h04
`define MBS_EXC_BUSY      8'h06
`define MBS_IN_BASE       16'h0000
`define MBS_IN_LAST       16'h00ff
`define MBS_OUT_BASE      16'h0800
`define MBS_OUT_LAST      16'h08ff
`define MBS_REG_BASE      16'h1000
`define MBS_REG_LAST      16'h1fff
`define MBS_REG_STATUS    16'h100c
`define MBS_REG_WDTIME    16'h1120
`define MBS_WDTIME_RST    16'h03e8
`define MBS_STAT_WD       15
`define MBS_STAT_TB       0
`define MBS_MAX_BITS      16'h07d0
`define MBS_MAX_WORDS     16'h007d
`define MBS_COIL_ON       8'hff
`define MBS_COIL_OFF      8'h00
`endif

// file: inc/mbs_pkg.sv
// types shared by the request interpreter
`default_nettype none
package mbs_pkg;
  typedef enum logic [1:0] {MBS_RECV, MBS_EXEC, MBS_SEND} mbs_state_t;
  typedef enum logic [2:0] {MBS_K_DROP, MBS_K_FWD, MBS_K_EXC, MBS_K_BITS, MBS_K_WORDS, MBS_K_ECHO} mbs_kind_t;
endpackage
`default_nettype wire

// file: rtl/mbs_image.sv
// input and output process images, word wide with bit access
`timescale 1ns/10ps
`default_nettype none
module mbs_image #(
  parameter int WORDS = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          rdOut,
  input  wire logic [AW-1:0] rdAddrA,
  input  wire logic [AW-1:0] rdAddrB,
  output logic      [15:0]   rdDataA,
  output logic      [15:0]   rdDataB,
  input  wire logic          wordWrEn,
  input  wire logic [AW-1:0] wordWrAddr,
  input  wire logic [15:0]   wordWrData,
  input  wire logic          bitWrEn,
  input  wire logic [AW+3:0] bitWrAddr,
  input  wire logic          bitWrVal,
  input  wire logic          inWrEn,
  input  wire logic [AW-1:0] inWrAddr,
  input  wire logic [15:0]   inWrData,
  input  wire logic [AW-1:0] outRdAddr,
  output logic      [15:0]   outRdData
);
  logic [15:0] inMem  [WORDS];
  logic [15:0] outMem [WORDS];

  // two combinational ports so a bit field spanning two words is read at once
  assign rdDataA = rdOut ? outMem[rdAddrA] : inMem[rdAddrA];
  assign rdDataB = rdOut ? outMem[rdAddrB] : inMem[rdAddrB];

  always_ff @(posedge clk)
  begin
    if (wordWrEn)
      outMem[wordWrAddr] <= wordWrData;
    else if (bitWrEn)
      outMem[bitWrAddr[AW+3:4]][bitWrAddr[3:0]] <= bitWrVal;
  end

  always_ff @(posedge clk)
  begin
    if (inWrEn)
      inMem[inWrAddr] <= inWrData;
  end

  always_ff @(posedge clk)
  begin
    outRdData <= outMem[outRdAddr];
  end
endmodule
`default_nettype wire

// file: rtl/mbs_slave.sv
// request interpreter for function codes 1 to 6 with error answers
`timescale 1ns/10ps
`default_nettype none
`include "mbs_cfg.svh"
module mbs_slave import mbs_pkg::*; #(
  parameter int WORDS          = 256,
  parameter int AW             = 8,
  parameter int OWNER_HOLD_CYC = `MBS_OWNER_HOLD_MS * (`MBS_CLK_HZ / 1000)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          rxValid,
  input  wire logic [7:0]    rxData,
  input  wire logic          rxLast,
  input  wire logic [31:0]   rxMaster,
  output logic               rxReady,
  output logic               txValid,
  output logic      [7:0]    txData,
  output logic               txLast,
  input  wire logic          txReady,
  input  wire logic          wdExpired,
  input  wire logic          termBusErr,
  output logic               fwdReq,
  output logic      [7:0]    fwdFunc,
  output logic               answerDone,
  output logic               errAnswer,
  output logic      [15:0]   wdTime,
  input  wire logic          inWrEn,
  input  wire logic [AW-1:0] inWrAddr,
  input  wire logic [15:0]   inWrData,
  input  wire logic [AW-1:0] outRdAddr,
  output logic      [15:0]   outRdData
);
  localparam logic [16:0] BIT_SPAN = 17'(WORDS * 16);

  mbs_state_t  state;
  mbs_kind_t   kind;
  mbs_kind_t   next_kind;
  logic [7:0]  reqBuf [12];
  logic [3:0]  rxCnt;
  logic [31:0] reqMaster;
  logic [7:0]  excCode;
  logic [7:0]  next_exc;
  logic [7:0]  pduLen;
  logic [7:0]  next_pduLen;
  logic [8:0]  txIdx;
  logic [15:0] curWord;
  logic [AW+3:0] curBit;
  logic [15:0] bitsLeft;
  logic        rdOut;
  logic        wordReg;
  logic        ownerValid;
  logic [31:0] ownerId;
  logic [31:0] holdCnt;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic [7:0]  fn;
  logic [15:0] addr;
  logic [15:0] qty;
  logic [16:0] endAddr;
  logic        fnImpl;
  logic        fnFwd;
  logic        hdrOk;
  logic        lenOk;
  logic        devErr;
  logic        isWrite;
  logic        areaIn;
  logic        areaOut;
  logic        areaReg;
  logic        inRegs;
  logic        addrBad;
  logic        valBad;
  logic        busy;
  logic        doWrite;

  assign fn      = reqBuf[`MBS_IDX_FUNC];
  assign addr    = {reqBuf[`MBS_IDX_ADDR], reqBuf[`MBS_IDX_ADDR + 4'h1]};
  assign qty     = {reqBuf[`MBS_IDX_QTY], reqBuf[`MBS_IDX_QTY + 4'h1]};
  assign endAddr = {1'b0, addr} + {1'b0, qty};
  assign fnImpl  = (fn >= `MBS_FN_RD_COILS) && (fn <= `MBS_FN_WR_REG);
  assign fnFwd   = (fn == `MBS_FN_DIAG) || (fn == `MBS_FN_WR_COILS) ||
                   (fn == `MBS_FN_WR_REGS) || (fn == `MBS_FN_RW_REGS);
  assign hdrOk   = (rxCnt >= `MBS_HDR_LEN) && (reqBuf[`MBS_IDX_PROTO] == 8'h00) &&
                   (reqBuf[`MBS_IDX_PROTO + 4'h1] == 8'h00);
  assign lenOk   = (rxCnt == `MBS_REQ_LEN);
  assign devErr  = wdExpired || termBusErr;
  assign isWrite = (fn == `MBS_FN_WR_COIL) || (fn == `MBS_FN_WR_REG);
  assign areaIn  = (addr <= `MBS_IN_LAST) && (endAddr <= {1'b0, `MBS_IN_LAST} + 17'h00001);
  assign areaOut = (addr >= `MBS_OUT_BASE) && (addr <= `MBS_OUT_LAST) &&
                   (endAddr <= {1'b0, `MBS_OUT_LAST} + 17'h00001);
  assign areaReg = ((addr == `MBS_REG_STATUS) || (addr == `MBS_REG_WDTIME)) && (qty == 16'h0001);
  assign inRegs  = (addr >= `MBS_REG_BASE) && (addr <= `MBS_REG_LAST);
  assign busy    = isWrite && ownerValid && (ownerId != reqMaster);

  always_comb
  begin
    addrBad = 1'b0;
    unique case (fn)
      `MBS_FN_RD_COILS, `MBS_FN_RD_INPUTS:
        addrBad = (qty == 16'h0000) || (qty > `MBS_MAX_BITS) || (endAddr > BIT_SPAN);
      `MBS_FN_RD_HOLD:
        addrBad = (qty == 16'h0000) || (qty > `MBS_MAX_WORDS) || !(areaIn || areaOut || areaReg);
      `MBS_FN_RD_INREG:
        addrBad = (qty == 16'h0000) || (qty > `MBS_MAX_WORDS) || !(areaIn || areaReg);
      `MBS_FN_WR_COIL:
        addrBad = ({1'b0, addr} >= BIT_SPAN);
      `MBS_FN_WR_REG:
        addrBad = !(((addr >= `MBS_OUT_BASE) && (addr <= `MBS_OUT_LAST)) || inRegs);
      default:
        addrBad = 1'b0;
    endcase
  end

  always_comb
  begin
    valBad = !lenOk;
    if (fn == `MBS_FN_WR_COIL)
      valBad = valBad || !(((reqBuf[`MBS_IDX_QTY] == `MBS_COIL_ON) || (reqBuf[`MBS_IDX_QTY] == `MBS_COIL_OFF)) &&
                           (reqBuf[`MBS_IDX_QTY + 4'h1] == 8'h00));
    if (fn == `MBS_FN_WR_REG)
      valBad = valBad || (inRegs && (addr != `MBS_REG_WDTIME));
  end

  // priority: function, device error, address, value, busy
  always_comb
  begin
    next_exc = 8'h00;
    if (!fnImpl)
      next_exc = `MBS_EXC_FUNC;
    else if (devErr)
      next_exc = `MBS_EXC_DEVICE;
    else if (lenOk && addrBad)
      next_exc = `MBS_EXC_ADDR;
    else if (valBad)
      next_exc = `MBS_EXC_VALUE;
    else if (busy)
      next_exc = `MBS_EXC_BUSY;
  end

  always_comb
  begin
    next_kind   = MBS_K_ECHO;
    next_pduLen = 8'h05;
    if (!hdrOk)
      next_kind = MBS_K_DROP;
    else if (fnFwd)
      next_kind = MBS_K_FWD;
    else if (next_exc != 8'h00)
    begin
      next_kind   = MBS_K_EXC;
      next_pduLen = 8'h02;
    end
    else if ((fn == `MBS_FN_RD_COILS) || (fn == `MBS_FN_RD_INPUTS))
    begin
      next_kind   = MBS_K_BITS;
      next_pduLen = 8'h02 + 8'((qty + 16'h0007) >> 3);
    end
    else if ((fn == `MBS_FN_RD_HOLD) || (fn == `MBS_FN_RD_INREG))
    begin
      next_kind   = MBS_K_WORDS;
      next_pduLen = 8'h02 + 8'(qty << 1);
    end
  end

  assign doWrite = (state == MBS_EXEC) && (next_kind == MBS_K_ECHO);

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  logic        load;
  logic [7:0]  pduIdx;
  logic [7:0]  txByte;
  logic [15:0] rdA;
  logic [15:0] rdB;
  logic [15:0] wordVal;
  logic [7:0]  bitMask;
  logic [7:0]  bitByte;
  logic        lastOut;

  // longest answer is 259 bytes, so the byte index needs nine bits
  assign load    = (state == MBS_SEND) && (!txValid || txReady) && (txIdx < 9'(pduLen) + 9'(`MBS_PDU_POS));
  assign lastOut = txValid && txReady && txLast;
  assign pduIdx  = 8'(txIdx - 9'(`MBS_PDU_POS));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state   <= MBS_RECV;
      rxReady <= 1'b0;
      rxCnt   <= 4'h0;
    end
    else
    begin
      unique case (state)
        MBS_RECV:
        begin
          rxReady <= 1'b1;
          if (rxValid && rxReady)
          begin
            if (rxCnt < `MBS_REQ_LEN)
              rxCnt <= rxCnt + 4'h1;
            if (rxLast)
            begin
              state   <= MBS_EXEC;
              rxReady <= 1'b0;
            end
          end
        end
        MBS_EXEC:
        begin
          rxCnt <= 4'h0;
          if ((next_kind == MBS_K_DROP) || (next_kind == MBS_K_FWD))
          begin
            state   <= MBS_RECV;
            rxReady <= 1'b1;
          end
          else
            state <= MBS_SEND;
        end
        MBS_SEND:
        begin
          if (lastOut)
          begin
            state   <= MBS_RECV;
            rxReady <= 1'b1;
          end
        end
        default:
          state <= MBS_RECV;
      endcase
    end
  end

  // bytes beyond the fixed part are not kept; functions 1 to 6 need none
  always_ff @(posedge clk)
  begin
    if ((state == MBS_RECV) && rxValid && rxReady && (rxCnt < `MBS_REQ_LEN))
    begin
      reqBuf[rxCnt] <= rxData;
      if (rxCnt == 4'h0)
        reqMaster <= rxMaster;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      kind    <= MBS_K_DROP;
      excCode <= 8'h00;
      pduLen  <= 8'h00;
      fwdReq  <= 1'b0;
      fwdFunc <= 8'h00;
    end
    else
    begin
      fwdReq <= (state == MBS_EXEC) && (next_kind == MBS_K_FWD);
      if (state == MBS_EXEC)
      begin
        kind    <= next_kind;
        excCode <= next_exc;
        pduLen  <= next_pduLen;
        fwdFunc <= fn;
      end
    end
  end

  // ---------------------------------------------------------------
  // read pointers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      curBit   <= '0;
      curWord  <= 16'h0000;
      bitsLeft <= 16'h0000;
      rdOut    <= 1'b0;
      wordReg  <= 1'b0;
    end
    else if (state == MBS_EXEC)
    begin
      curBit   <= addr[AW+3:0];
      curWord  <= addr;
      bitsLeft <= qty;
      rdOut    <= (fn == `MBS_FN_RD_COILS) || ((fn == `MBS_FN_RD_HOLD) && areaOut);
      wordReg  <= areaReg;
    end
    // header bytes must not move the pointers
    else if (load && (txIdx >= 9'(`MBS_PDU_POS) + 9'h002))
    begin
      if (kind == MBS_K_BITS)
      begin
        curBit   <= curBit + (AW+4)'(8);
        bitsLeft <= (bitsLeft > 16'h0008) ? bitsLeft - 16'h0008 : 16'h0000;
      end
      if ((kind == MBS_K_WORDS) && pduIdx[0])
        curWord <= curWord + 16'h0001;
    end
  end

  mbs_image #(
    .WORDS (WORDS),
    .AW    (AW)
  ) image (
    .clk        (clk),
    .rdOut      (rdOut),
    .rdAddrA    ((kind == MBS_K_BITS) ? curBit[AW+3:4] : curWord[AW-1:0]),
    .rdAddrB    (curBit[AW+3:4] + AW'(1)),
    .rdDataA    (rdA),
    .rdDataB    (rdB),
    .wordWrEn   (doWrite && (fn == `MBS_FN_WR_REG) && !inRegs),
    .wordWrAddr (addr[AW-1:0]),
    .wordWrData (qty),
    .bitWrEn    (doWrite && (fn == `MBS_FN_WR_COIL)),
    .bitWrAddr  (addr[AW+3:0]),
    .bitWrVal   (reqBuf[`MBS_IDX_QTY] == `MBS_COIL_ON),
    .inWrEn     (inWrEn),
    .inWrAddr   (inWrAddr),
    .inWrData   (inWrData),
    .outRdAddr  (outRdAddr),
    .outRdData  (outRdData)
  );

  // ---------------------------------------------------------------
  // answer bytes
  // ---------------------------------------------------------------
  always_comb
  begin
    wordVal = rdA;
    if (wordReg)
    begin
      wordVal = wdTime;
      if (curWord == `MBS_REG_STATUS)
      begin
        wordVal = 16'h0000;
        wordVal[`MBS_STAT_WD] = wdExpired;
        wordVal[`MBS_STAT_TB] = termBusErr;
      end
    end
  end

  assign bitMask = (bitsLeft >= 16'h0008) ? 8'hff : 8'(8'hff >> (4'h8 - bitsLeft[3:0]));
  assign bitByte = 8'({rdB, rdA} >> curBit[3:0]) & bitMask;

  always_comb
  begin
    txByte = 8'h00;
    unique case (txIdx)
      9'h000, 9'h001: txByte = reqBuf[txIdx[3:0]];
      9'h002, 9'h003, 9'h004: txByte = 8'h00;
      9'h005: txByte = pduLen + 8'h01;
      9'h006: txByte = reqBuf[`MBS_IDX_UNIT];
      default:
      begin
        unique case (kind)
          MBS_K_EXC: txByte = (pduIdx == 8'h00) ? (fn | `MBS_EXC_FLAG) : excCode;
          MBS_K_ECHO: txByte = reqBuf[txIdx[3:0]];
          MBS_K_BITS, MBS_K_WORDS:
          begin
            if (pduIdx == 8'h00)
              txByte = fn;
            else if (pduIdx == 8'h01)
              txByte = pduLen - 8'h02;
            else if (kind == MBS_K_BITS)
              txByte = bitByte;
            else
              txByte = pduIdx[0] ? wordVal[7:0] : wordVal[15:8];
          end
          default: txByte = 8'h00;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txValid    <= 1'b0;
      txData     <= 8'h00;
      txLast     <= 1'b0;
      txIdx      <= 9'h000;
      answerDone <= 1'b0;
      errAnswer  <= 1'b0;
    end
    else
    begin
      answerDone <= lastOut;
      errAnswer  <= lastOut && (kind == MBS_K_EXC);
      if (state == MBS_EXEC)
        txIdx <= 9'h000;
      if (load)
      begin
        txValid <= 1'b1;
        txData  <= txByte;
        txLast  <= (txIdx == 9'(pduLen) + 9'(`MBS_PDU_POS) - 9'h001);
        txIdx   <= txIdx + 9'h001;
      end
      else if (txValid && txReady)
      begin
        txValid <= 1'b0;
        txLast  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output ownership and interface register
  // ---------------------------------------------------------------
  // a claim in the cycle the hold runs out wins, so the owner is not lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ownerValid <= 1'b0;
      ownerId    <= 32'h00000000;
      holdCnt    <= 32'h00000000;
    end
    else if (doWrite)
    begin
      ownerValid <= 1'b1;
      ownerId    <= reqMaster;
      holdCnt    <= 32'(OWNER_HOLD_CYC);
    end
    else if (holdCnt != 32'h00000000)
      holdCnt <= holdCnt - 32'h00000001;
    else
      ownerValid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wdTime <= `MBS_WDTIME_RST;
    else if (doWrite && (fn == `MBS_FN_WR_REG) && (addr == `MBS_REG_WDTIME))
      wdTime <= qty;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hdrLoad_s;
    load && (txIdx == 8'h00);
  endsequence

  exc_flag_a: assert property (load && (kind == MBS_K_EXC) && (txIdx == 8'h07) |=> txData == (fn | 8'h80))
    else $error("error answer lacks 0x80 flag");
  exc_func_a: assert property ((state == MBS_EXEC) && hdrOk && !fnImpl && !fnFwd |=> (kind == MBS_K_EXC) && (excCode == 8'h01))
    else $error("unimplemented function not refused");
  exc_range_a: assert property ((state == MBS_EXEC) && hdrOk && lenOk && (fn == 8'h01) && !devErr && (qty == 16'h0000) |=> excCode == 8'h02)
    else $error("zero bit count not refused");
  exc_coil_a: assert property ((state == MBS_EXEC) && lenOk && (fn == 8'h05) && !devErr && !addrBad && (reqBuf[11] != 8'h00) |=> excCode == 8'h03)
    else $error("bad coil value accepted");
  exc_dev_a: assert property ((state == MBS_EXEC) && hdrOk && fnImpl && devErr |=> (kind == MBS_K_EXC) && (excCode == 8'h04))
    else $error("device error not reported");
  exc_busy_a: assert property ((state == MBS_EXEC) && hdrOk && lenOk && isWrite && !devErr && !valBad &&
                               !addrBad && ownerValid && (ownerId != reqMaster) |=> (kind == MBS_K_EXC) && (excCode == 8'h06))
    else $error("foreign write not refused busy");
  fwd_func_a: assert property ((state == MBS_EXEC) && hdrOk && (fn == 8'h10) |=> fwdReq && (state == MBS_RECV))
    else $error("listed function not passed on");
  bit_count_a: assert property (load && (kind == MBS_K_BITS) && (txIdx == 8'h08) |=> txData == 8'(({8'h00, qty} + 24'h7) >> 3))
    else $error("bit byte count wrong");
  word_count_a: assert property (load && (kind == MBS_K_WORDS) && (txIdx == 8'h08) |=> txData == 8'(qty << 1))
    else $error("word byte count wrong");
  bit_pad_a: assert property (load && (kind == MBS_K_BITS) && (txIdx > 8'h08) && (bitsLeft < 16'h0008)
                              |=> (txData >> $past(bitsLeft[3:0])) == 8'h00)
    else $error("bits beyond count not zero");
  echo_val_a: assert property (load && (kind == MBS_K_ECHO) && (txIdx == 8'h0b) |=> txData == reqBuf[11])
    else $error("echo byte differs");
  hdr_copy_a: assert property (hdrLoad_s |=> (txData == reqBuf[0]) ##[1:40] (txValid && (txData == 8'h00)))
    else $error("header not copied");
endmodule
`default_nettype wire
